// File: logic/lrft_pkg.sv
// Constants, types and command codes of the radio frame transfer block.
// Assumes one 250 MHz system clock and a host that speaks SPI mode 0.
package lrft_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int LQI_TIME_US = 64;
	localparam int CCA_TIME_US = 128;
	localparam int LQI_CYC_DEF = LQI_TIME_US * CLK_MHZ;
	localparam int CCA_CYC_DEF = CCA_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam logic [2:0] PRE_LEN = 3'h4;
	localparam logic [7:0] PRE_BYTE = 8'h00;
	localparam logic [7:0] SFD_BYTE = 8'hA7;
	localparam logic [6:0] FCS_LEN = 7'h02;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'h0000;

	// ----------------------------------------
	// Buffers
	// ----------------------------------------
	localparam int TX_DEPTH = 128;
	localparam int RX_DEPTH = 130;
	localparam logic [7:0] RX_LQI_IDX = 8'h80;
	localparam logic [7:0] RX_CRC_IDX = 8'h81;

	// ----------------------------------------
	// Host commands and interrupt flags
	// ----------------------------------------
	localparam logic [7:0] CMD_WR_TXBUF = 8'h01;
	localparam logic [7:0] CMD_TX_START = 8'h02;
	localparam logic [7:0] CMD_RD_RXBUF = 8'h03;
	localparam logic [7:0] CMD_WR_WORD = 8'h04;
	localparam logic [7:0] CMD_RD_WORD = 8'h05;
	localparam logic [7:0] CMD_RD_STATUS = 8'h06;
	localparam int FLG_RXF = 0;
	localparam int FLG_RXW = 1;
	localparam int FLG_TXD = 2;
	localparam int FLG_TXW = 3;

	typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_LEN, T_PAY, T_FCL, T_FCH, T_DONE} lrft_tx_t;
	typedef enum logic [1:0] {R_HUNT, R_LEN, R_DATA} lrft_rx_t;

endpackage

// File: logic/lrft_frame_xfer.sv
// Frame transfer core: SPI host port, packet and stream modes, framer,
// deframer with CRC check, link quality and channel energy measurement.
// Assumes modem byte ports on the system clock; SPI pins are asynchronous.
//
// Behaviour
// [RL1] Host talks over four-wire SPI plus one interrupt request line.
// [RL2] Packet mode buffers whole frames in RAM; stream mode moves single words.
// [RL3] Transmit sends four preamble bytes, delimiter, then length field before payload.
// [RL4] Payload is at most 125 bytes; every length up to that works.
// [RL5] Two-byte check sequence is computed and appended after the payload.
// [RL6] Receive finds preamble, delimiter, length, and stores payload and check bytes.
// [RL7] Receive recomputes the check sequence and reports pass or fail.
// [RL8] Link quality is measured over 64 us after the preamble and stored.
// [RL9] Packet receive interrupts once, only when the whole frame is in.
// [RL10] Stream receive interrupts for every received word.
// [RL11] Host fills the transmit buffer fully before asking to transmit.
// [RL12] Packet transmit interrupts when the whole frame has been sent.
// [RL13] Stream transmit interrupts whenever a word can be taken; host supplies it.
// [RL14] Clear channel assessment integrates energy over a fixed interval.
// [RL15] Length field counts payload plus check bytes; receiver ends frame by it.
module lrft_frame_xfer import lrft_pkg::*; #(
	parameter int LQI_CYC = LQI_CYC_DEF,
	parameter int CCA_CYC = CCA_CYC_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_spi_sclk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe,
	output logic o_irq_n,
	input wire logic i_stream_mode,
	output logic [7:0] o_tx_byte,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_energy,
	input wire logic i_cca_start,
	input wire logic [7:0] i_cca_thresh,
	output logic o_cca_busy,
	output logic o_cca_done
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] cs_s;
		logic [1:0] mosi_s;
		logic [2:0] bitc;
		logic [7:0] sin;
		logic [7:0] sout;
		logic first;
		logic [7:0] cmd;
		logic [7:0] ptr;
		logic [3:0] flg;
		logic irq_n;
		lrft_tx_t ts;
		logic [6:0] tcnt;
		logic [15:0] tcrc;
		logic [7:0] tlen;
		logic txv;
		logic [7:0] txb;
		logic [7:0] hold_tx;
		logic hold_txv;
		logic [7:0] hold_rx;
		lrft_rx_t rs;
		logic [2:0] zc;
		logic [6:0] rlen;
		logic [6:0] rcnt;
		logic [15:0] rcrc;
		logic [7:0] fcs_lo;
		logic crc_ok;
		logic [15:0] lqi_cnt;
		logic [7:0] lqi;
		logic lqi_pend;
		logic [15:0] cca_cnt;
		logic [23:0] cca_sum;
		logic cca_busy;
		logic cca_done;
	} lrft_st_t;

	lrft_st_t s_r;
	lrft_st_t s_nxt;
	logic [7:0] tx_ram [TX_DEPTH];
	logic [7:0] rx_ram [RX_DEPTH];
	logic tx_we;
	logic [6:0] tx_wa;
	logic [7:0] tx_wd;
	logic rx_we;
	logic [7:0] rx_wa;
	logic [7:0] rx_wd;
	logic tx_start;
	logic tx_adv;
	logic tx_busy;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [7:0] rx_rd(input logic [7:0] idx, input logic ok);
		logic [7:0] v;
		v = 8'h00;
		if (idx == RX_CRC_IDX) begin
			v = {7'h00, ok};
		end else if (idx < 8'(RX_DEPTH)) begin
			v = rx_ram[idx];
		end
		return v;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic rise;
		logic fall;
		logic [7:0] b;
		logic [7:0] d;
		logic go;
		logic [3:0] ev;
		logic [3:0] clr;
		rise = 1'b0;
		fall = 1'b0;
		b = 8'h00;
		d = 8'h00;
		go = 1'b0;
		ev = 4'h0;
		clr = 4'h0;
		s_nxt = s_r;
		tx_we = 1'b0;
		tx_wa = 7'h00;
		tx_wd = 8'h00;
		rx_we = 1'b0;
		rx_wa = 8'h00;
		rx_wd = 8'h00;
		tx_start = 1'b0;
		tx_busy = s_r.ts != T_IDLE;
		tx_adv = !s_r.txv || i_tx_ready;

		// SPI slave, mode 0, sampled by the system clock [RL1]
		s_nxt.sclk_s = {s_r.sclk_s[1:0], i_spi_sclk};
		s_nxt.cs_s = {s_r.cs_s[1:0], i_spi_cs_n};
		s_nxt.mosi_s = {s_r.mosi_s[0], i_spi_mosi};
		rise = s_r.sclk_s[1] && !s_r.sclk_s[2];
		fall = !s_r.sclk_s[1] && s_r.sclk_s[2];
		if (s_r.cs_s[1]) begin
			s_nxt.bitc = 3'h0;
			s_nxt.first = 1'b1;
			s_nxt.sout = 8'h00;
		end else begin
			if (rise) begin
				b = {s_r.sin[6:0], s_r.mosi_s[1]};
				s_nxt.sin = b;
				s_nxt.bitc = s_r.bitc + 3'h1;
				if (s_r.bitc == 3'h7 && s_r.first) begin
					s_nxt.first = 1'b0;
					s_nxt.cmd = b;
					s_nxt.ptr = 8'h00;
					case (b)
						CMD_TX_START: tx_start = 1'b1;
						CMD_RD_STATUS: begin
							s_nxt.sout = {s_r.flg, s_r.crc_ok, s_r.cca_busy, tx_busy, s_r.hold_txv};
							clr = 4'hF;
						end
						CMD_RD_RXBUF: begin
							s_nxt.sout = rx_rd(8'h00, s_r.crc_ok);
							s_nxt.ptr = 8'h01;
						end
						CMD_RD_WORD: begin
							s_nxt.sout = s_r.hold_rx;
							clr[FLG_RXW] = 1'b1;
						end
						default: s_nxt.sout = 8'h00;
					endcase
				end else if (s_r.bitc == 3'h7) begin
					case (s_r.cmd)
						CMD_WR_TXBUF: begin // [RL11]
							tx_we = s_r.ptr < 8'(TX_DEPTH);
							tx_wa = s_r.ptr[6:0];
							tx_wd = b;
							s_nxt.ptr = s_r.ptr + 8'h01;
						end
						CMD_RD_RXBUF: begin
							s_nxt.sout = rx_rd(s_r.ptr, s_r.crc_ok);
							s_nxt.ptr = s_r.ptr + 8'h01;
						end
						CMD_WR_WORD: begin // [RL13]
							s_nxt.hold_tx = b;
							s_nxt.hold_txv = 1'b1;
							clr[FLG_TXW] = 1'b1;
						end
						default: s_nxt.ptr = s_r.ptr;
					endcase
				end
			end
			if (fall && s_r.bitc != 3'h0) begin
				s_nxt.sout = {s_r.sout[6:0], 1'b0};
			end
		end

		// Framer [RL2] [RL3] [RL5]
		if (s_r.txv && i_tx_ready) begin
			s_nxt.txv = 1'b0;
		end
		d = i_stream_mode ? s_r.hold_tx : tx_ram[7'(s_r.tcnt + 7'h01)];
		go = tx_adv && (!i_stream_mode || s_r.hold_txv);
		case (s_r.ts)
			T_IDLE: if (tx_start) begin
				s_nxt.ts = T_PRE;
				s_nxt.tcnt = 7'h00;
				s_nxt.tcrc = CRC_INIT;
				s_nxt.tlen = tx_ram[0];
			end
			T_PRE: if (tx_adv) begin
				s_nxt.txv = 1'b1;
				s_nxt.txb = PRE_BYTE; // [RL3]
				s_nxt.tcnt = s_r.tcnt + 7'h01;
				if (s_r.tcnt == 7'(PRE_LEN - 3'h1)) begin
					s_nxt.ts = T_SFD;
				end
			end
			T_SFD: if (tx_adv) begin
				s_nxt.txv = 1'b1;
				s_nxt.txb = SFD_BYTE; // [RL3]
				s_nxt.ts = T_LEN;
			end
			T_LEN: if (go) begin
				b = i_stream_mode ? s_r.hold_tx : s_r.tlen;
				s_nxt.hold_txv = 1'b0;
				s_nxt.txv = 1'b1;
				s_nxt.txb = b; // [RL15]
				s_nxt.tlen = b;
				s_nxt.tcnt = 7'h00;
				s_nxt.ts = (b[6:0] <= FCS_LEN) ? T_FCL : T_PAY; // [RL4]
			end
			T_PAY: if (go) begin
				s_nxt.hold_txv = 1'b0;
				s_nxt.txv = 1'b1;
				s_nxt.txb = d;
				s_nxt.tcrc = crc_upd(s_r.tcrc, d); // [RL5]
				s_nxt.tcnt = s_r.tcnt + 7'h01;
				if (7'(s_r.tcnt + 7'h01) == 7'(s_r.tlen[6:0] - FCS_LEN)) begin
					s_nxt.ts = T_FCL;
				end
			end
			T_FCL: if (tx_adv) begin
				s_nxt.txv = 1'b1;
				s_nxt.txb = s_r.tcrc[7:0]; // [RL5]
				s_nxt.ts = T_FCH;
			end
			T_FCH: if (tx_adv) begin
				s_nxt.txv = 1'b1;
				s_nxt.txb = s_r.tcrc[15:8];
				s_nxt.ts = T_DONE;
			end
			T_DONE: if (s_r.txv && i_tx_ready) begin
				s_nxt.ts = T_IDLE;
				ev[FLG_TXD] = 1'b1; // [RL12]
			end
			default: s_nxt.ts = T_IDLE;
		endcase
		ev[FLG_TXW] = i_stream_mode && !s_nxt.hold_txv && (s_nxt.ts == T_LEN || s_nxt.ts == T_PAY); // [RL13]

		// Deframer [RL6] [RL7]
		if (i_rx_valid) begin
			case (s_r.rs)
				R_HUNT: begin
					s_nxt.zc = 3'h0;
					if (i_rx_byte == PRE_BYTE) begin
						s_nxt.zc = (s_r.zc < PRE_LEN) ? s_r.zc + 3'h1 : s_r.zc;
					end else if (i_rx_byte == SFD_BYTE && s_r.zc >= PRE_LEN) begin
						s_nxt.rs = R_LEN;
						s_nxt.lqi_cnt = 16'(LQI_CYC); // [RL8]
						s_nxt.lqi = 8'h00;
					end
				end
				R_LEN: begin
					s_nxt.rlen = i_rx_byte[6:0];
					s_nxt.rcnt = 7'h00;
					s_nxt.rcrc = CRC_INIT;
					s_nxt.rs = (i_rx_byte[6:0] < FCS_LEN) ? R_HUNT : R_DATA;
					rx_we = 1'b1;
					rx_wa = 8'h00;
					rx_wd = i_rx_byte;
					s_nxt.hold_rx = i_rx_byte;
					ev[FLG_RXW] = i_stream_mode; // [RL10]
				end
				R_DATA: begin
					rx_we = 1'b1;
					rx_wa = {1'b0, s_r.rcnt} + 8'h01;
					rx_wd = i_rx_byte;
					s_nxt.hold_rx = i_rx_byte;
					ev[FLG_RXW] = i_stream_mode; // [RL10]
					s_nxt.rcnt = s_r.rcnt + 7'h01;
					if (s_r.rcnt < 7'(s_r.rlen - FCS_LEN)) begin
						s_nxt.rcrc = crc_upd(s_r.rcrc, i_rx_byte);
					end
					if (s_r.rcnt == 7'(s_r.rlen - FCS_LEN)) begin
						s_nxt.fcs_lo = i_rx_byte;
					end
					if (s_r.rcnt == 7'(s_r.rlen - 7'h01)) begin // [RL15]
						s_nxt.crc_ok = {i_rx_byte, s_r.fcs_lo} == s_r.rcrc; // [RL7]
						s_nxt.rs = R_HUNT;
						s_nxt.zc = 3'h0;
						ev[FLG_RXF] = !i_stream_mode; // [RL9]
					end
				end
				default: s_nxt.rs = R_HUNT;
			endcase
		end

		// Link quality: peak energy over the window after the preamble [RL8]
		if (s_r.lqi_cnt != 16'h0000) begin
			s_nxt.lqi_cnt = s_r.lqi_cnt - 16'h0001;
			s_nxt.lqi = (i_energy > s_r.lqi) ? i_energy : s_r.lqi;
			s_nxt.lqi_pend = s_r.lqi_cnt == 16'h0001;
		end else if (s_r.lqi_pend && !rx_we) begin
			rx_we = 1'b1;
			rx_wa = RX_LQI_IDX;
			rx_wd = s_r.lqi;
			s_nxt.lqi_pend = 1'b0;
		end

		// Clear channel assessment [RL14]
		if (i_cca_start && s_r.cca_cnt == 16'h0000) begin
			s_nxt.cca_cnt = 16'(CCA_CYC);
			s_nxt.cca_sum = 24'h000000;
			s_nxt.cca_done = 1'b0;
		end else if (s_r.cca_cnt != 16'h0000) begin
			s_nxt.cca_cnt = s_r.cca_cnt - 16'h0001;
			s_nxt.cca_sum = s_r.cca_sum + {16'h0000, i_energy};
			if (s_r.cca_cnt == 16'h0001) begin
				s_nxt.cca_busy = 32'(s_nxt.cca_sum) >= 32'(i_cca_thresh) * 32'(CCA_CYC);
				s_nxt.cca_done = 1'b1;
			end
		end

		// Sticky flags, a new event beats a clear [RL1]
		s_nxt.flg = (s_r.flg & ~clr) | ev;
		s_nxt.irq_n = ~|s_nxt.flg;
	end

	// ----------------------------------------
	// Registers and buffers
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
			s_r.sclk_s <= 3'h0;
			s_r.cs_s <= 3'h7;
			s_r.first <= 1'b1;
			s_r.irq_n <= 1'b1;
			s_r.ts <= T_IDLE;
			s_r.rs <= R_HUNT;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (tx_we) begin
			tx_ram[tx_wa] <= tx_wd;
		end
		if (rx_we) begin
			rx_ram[rx_wa] <= rx_wd;
		end
	end

	assign o_spi_miso = s_r.sout[7];
	assign o_spi_miso_oe = !s_r.cs_s[2];
	assign o_irq_n = s_r.irq_n;
	assign o_tx_byte = s_r.txb;
	assign o_tx_valid = s_r.txv;
	assign o_cca_busy = s_r.cca_busy;
	assign o_cca_done = s_r.cca_done;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence SEQ_TX_GO;
		s_r.ts == T_IDLE && tx_start;
	endsequence
	sequence SEQ_PRE_OUT;
		s_r.ts == T_PRE ##1 (s_r.txv && s_r.txb == PRE_BYTE);
	endsequence

	AST_TX_PREAMBLE: assert property (SEQ_TX_GO |=> SEQ_PRE_OUT) // [RL3]
		else $error("preamble not first after start");
	AST_TX_SFD: assert property (s_r.ts == T_SFD && tx_adv |=> s_r.txv && s_r.txb == SFD_BYTE) // [RL3]
		else $error("delimiter byte wrong");
	AST_TX_LEN: assert property (s_r.ts == T_LEN && !i_stream_mode && tx_adv // [RL15]
		|=> s_r.txb == s_r.tlen && s_r.ts != T_LEN)
		else $error("length field not sent");
	AST_TX_FCS: assert property (s_r.ts == T_FCL && tx_adv |=> s_r.txb == s_r.tcrc[7:0]) // [RL5]
		else $error("check sequence low byte wrong");
	AST_TX_DONE: assert property (s_r.ts == T_DONE && s_r.txv && i_tx_ready // [RL12]
		|=> s_r.flg[FLG_TXD] && !o_irq_n)
		else $error("no interrupt after frame sent");
	AST_TX_WORD: assert property (i_stream_mode && (s_r.ts == T_LEN || s_r.ts == T_PAY) // [RL13]
		&& !s_r.hold_txv |=> (s_r.flg[FLG_TXW] && !o_irq_n) || s_r.hold_txv)
		else $error("no word request interrupt");
	AST_RX_FRAME: assert property (!i_stream_mode && i_rx_valid && s_r.rs == R_DATA // [RL9]
		&& s_r.rcnt == 7'(s_r.rlen - 7'h01) |=> s_r.flg[FLG_RXF] && s_r.rs == R_HUNT)
		else $error("frame end not flagged");
	AST_RX_WORD: assert property (i_stream_mode && i_rx_valid && s_r.rs != R_HUNT // [RL10]
		|=> s_r.flg[FLG_RXW] && s_r.hold_rx == $past(i_rx_byte))
		else $error("received word not flagged");
	AST_LQI_STORE: assert property (s_r.lqi_cnt == 16'h0001 |=> s_r.lqi_pend ##[1:3] !s_r.lqi_pend) // [RL8]
		else $error("link quality not stored");

endmodule

// File: tb/lrft_host_model.sv
// Host controller model: SPI mode 0 master, one byte per word.
// Assumes the bench fills mo, calls xfer and reads replies from mi.
module lrft_host_model (
	input wire logic i_sys_clk,
	input wire logic i_spi_miso,
	input wire logic i_spi_miso_oe,
	output logic o_spi_sclk,
	output logic o_spi_cs_n,
	output logic o_spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mo[$];
	logic [7:0] mi[$];
	logic miso_w;

	// Released line reads as pulled up
	assign miso_w = i_spi_miso_oe ? i_spi_miso : 1'b1;

	initial begin
		o_spi_sclk = 1'b0;
		o_spi_cs_n = 1'b1;
		o_spi_mosi = 1'b0;
	end

	// ----------------------------------------
	// One select frame, MSB first
	// ----------------------------------------
	task automatic xfer();
		logic [7:0] t;
		logic [7:0] r;
		mi.delete();
		@(posedge i_sys_clk);
		o_spi_cs_n <= 1'b0;
		foreach (mo[k]) begin
			t = mo[k];
			for (int b = 7; b >= 0; b--) begin
				o_spi_mosi <= t[b];
				repeat (20) @(posedge i_sys_clk);
				r[b] = miso_w;
				o_spi_sclk <= 1'b1;
				repeat (20) @(posedge i_sys_clk);
				o_spi_sclk <= 1'b0;
			end
			mi.push_back(r);
		end
		repeat (20) @(posedge i_sys_clk);
		o_spi_cs_n <= 1'b1;
		o_spi_mosi <= ~o_spi_mosi;
		repeat (20) @(posedge i_sys_clk);
		mo.delete();
	endtask
endmodule

// File: tb/lrft_frame_xfer_bench.sv
// Bench for the frame transfer core: packet and stream traffic, CCA.
// Assumes the host model drives SPI; the bench plays the modem.
module lrft_frame_xfer_bench import lrft_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, rst_n, sclk, cs_n, mosi, miso, miso_oe, irq_n, smode;
	logic tx_valid, tx_ready, rx_valid, cca_start, cca_busy, cca_done;
	logic [7:0] tx_byte, rx_byte, energy, thresh;
	int errors, cmp_count, cyc;
	logic [7:0] txq[$];

	lrft_frame_xfer #(.LQI_CYC(40), .CCA_CYC(64)) i_lrft_frame_xfer (
		.i_sys_clk(sys_clk),
		.i_resetn(rst_n),
		.i_spi_sclk(sclk),
		.i_spi_cs_n(cs_n),
		.i_spi_mosi(mosi),
		.o_spi_miso(miso),
		.o_spi_miso_oe(miso_oe),
		.o_irq_n(irq_n),
		.i_stream_mode(smode),
		.o_tx_byte(tx_byte),
		.o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready),
		.i_rx_byte(rx_byte),
		.i_rx_valid(rx_valid),
		.i_energy(energy),
		.i_cca_start(cca_start),
		.i_cca_thresh(thresh),
		.o_cca_busy(cca_busy),
		.o_cca_done(cca_done)
	);

	lrft_host_model i_lrft_host_model (
		.i_sys_clk(sys_clk),
		.i_spi_miso(miso),
		.i_spi_miso_oe(miso_oe),
		.o_spi_sclk(sclk),
		.o_spi_cs_n(cs_n),
		.o_spi_mosi(mosi)
	);

	always #2 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			conclude();
		end
	end

	// Modem side: record every byte taken
	always @(posedge sys_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			txq.push_back(tx_byte);
	end

	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction

	task automatic wirq(input logic v);
		int w;
		w = 0;
		@(negedge sys_clk);
		while (irq_n !== v && w < 100) begin
			@(negedge sys_clk);
			w++;
		end
		chk("irq_n", irq_n, v);
		@(posedge sys_clk);
	endtask

	task automatic cmd(input logic [7:0] c, output logic [7:0] r);
		i_lrft_host_model.mo = '{c, 8'h00};
		i_lrft_host_model.xfer();
		r = i_lrft_host_model.mi[1];
	endtask

	task automatic rxb(input logic [7:0] b);
		@(posedge sys_clk);
		rx_byte <= b;
		rx_valid <= 1'b1;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_tx_pkt();
		logic [7:0] e[$];
		logic [15:0] c;
		logic [7:0] r;
		int w;
		c = CRC_INIT;
		e = '{8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE, 8'h05};
		i_lrft_host_model.mo = '{CMD_WR_TXBUF, 8'h05};
		for (int k = 1; k <= 3; k++) begin
			i_lrft_host_model.mo.push_back(8'(k * 17));
			e.push_back(8'(k * 17));
			c = crc_add(c, 8'(k * 17));
		end
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		i_lrft_host_model.xfer();
		i_lrft_host_model.mo = '{CMD_TX_START};
		i_lrft_host_model.xfer();
		chk("tx_valid", tx_valid, 1'b1);
		tx_ready <= 1'b1;
		foreach (e[k]) begin
			w = 0;
			@(negedge sys_clk);
			while (tx_valid !== 1'b1 && w < 200) begin
				@(negedge sys_clk);
				w++;
			end
			if (k == e.size() - 1)
				chk("irq_n", irq_n, 1'b1);
			chk("tx_byte", tx_byte, e[k]);
			@(posedge sys_clk);
		end
		wirq(1'b0);
		cmd(CMD_RD_STATUS, r);
		chk("tx_done", r[FLG_TXD + 4], 1'b1);
		wirq(1'b1);
	endtask

	task automatic t_rx_pkt(input logic bad);
		logic [7:0] f[$];
		logic [15:0] c;
		logic [7:0] r;
		c = CRC_INIT;
		f = '{8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE, 8'h05, 8'h3C, 8'hC3, 8'h7E};
		for (int k = 6; k < 9; k++)
			c = crc_add(c, f[k]);
		f.push_back(c[7:0]);
		f.push_back(c[15:8] ^ {7'h00, bad});
		energy <= 8'h5A;
		foreach (f[k]) begin
			if (k == 10)
				chk("irq_n", irq_n, 1'b1);
			rxb(f[k]);
		end
		wirq(1'b0);
		repeat (50) @(posedge sys_clk);
		energy <= 8'h00;
		cmd(CMD_RD_STATUS, r);
		chk("rx_frame", r[FLG_RXF + 4], 1'b1);
		chk("crc_ok", r[3], !bad);
		if (!bad) begin
			i_lrft_host_model.mo = '{CMD_RD_RXBUF};
			repeat (130) i_lrft_host_model.mo.push_back(8'h00);
			i_lrft_host_model.xfer();
			for (int k = 5; k < 11; k++)
				chk("rx_ram", i_lrft_host_model.mi[k - 4], f[k]);
			chk("lqi", i_lrft_host_model.mi[129], 8'h5A);
			chk("crc_ram", i_lrft_host_model.mi[130][0], 1'b1);
		end
	endtask

	task automatic t_rx_str();
		logic [7:0] f[$];
		logic [7:0] r;
		smode <= 1'b1;
		f = '{8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE, 8'h03, 8'h96, 8'h12, 8'h34};
		foreach (f[k]) begin
			rxb(f[k]);
			if (k > 4) begin
				wirq(1'b0);
				cmd(CMD_RD_WORD, r);
				chk("rx_word", r, f[k]);
				wirq(1'b1);
			end
		end
		smode <= 1'b0;
	endtask

	task automatic t_tx_str();
		logic [7:0] e[$];
		logic [7:0] w[$];
		logic [15:0] c;
		logic [7:0] r;
		@(posedge sys_clk);
		smode <= 1'b1;
		c = crc_add(CRC_INIT, 8'h5C);
		w = '{8'h03, 8'h5C};
		e = '{8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE, 8'h03, 8'h5C, c[7:0], c[15:8]};
		txq.delete();
		i_lrft_host_model.mo = '{CMD_TX_START};
		i_lrft_host_model.xfer();
		foreach (w[k]) begin
			wirq(1'b0);
			cmd(CMD_RD_STATUS, r);
			chk("tx_word_req", r[FLG_TXW + 4], 1'b1);
			i_lrft_host_model.mo = '{CMD_WR_WORD, w[k]};
			i_lrft_host_model.xfer();
		end
		wirq(1'b0);
		cmd(CMD_RD_STATUS, r);
		chk("tx_done", r[FLG_TXD + 4], 1'b1);
		chk("tx_word_req", r[FLG_TXW + 4], 1'b0);
		wirq(1'b1);
		chk("tx_count", 8'(txq.size()), 8'(e.size()));
		foreach (e[k])
			chk("tx_byte", txq[k], e[k]);
		smode <= 1'b0;
	endtask

	task automatic t_cca();
		int w;
		for (int k = 0; k < 2; k++) begin
			thresh <= 8'h10;
			energy <= k ? 8'h0F : 8'h10;
			cca_start <= 1'b1;
			@(posedge sys_clk);
			cca_start <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk("cca_done", cca_done, 1'b0);
			w = 0;
			while (cca_done !== 1'b1 && w < 200) begin
				@(posedge sys_clk);
				w++;
			end
			chk("cca_busy", cca_busy, k ? 1'b0 : 1'b1);
		end
	endtask

	initial begin
		{sys_clk, rst_n, smode, tx_ready, rx_valid, cca_start} = '0;
		{rx_byte, energy, thresh} = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk("irq_n", irq_n, 1'b1);
		chk("tx_valid", tx_valid, 1'b0);
		chk("miso_oe", miso_oe, 1'b0);
		repeat (5) @(posedge sys_clk);
		t_tx_pkt();
		$display("tx_pkt done");
		t_rx_pkt(1'b1);
		t_rx_pkt(1'b0);
		$display("rx_pkt done");
		t_rx_str();
		$display("rx_str done");
		t_tx_str();
		$display("tx_str done");
		t_cca();
		$display("cca done");
		conclude();
	end
endmodule
